// *** rtl/sdwfb_pkg.sv ***
`default_nettype none

package sdwfb_pkg;

  // clock and timing
  localparam int CLK_MHZ        = 200;
  localparam int SELECT_LOW_US  = 2000;
  localparam int SELECT_LOW_CYC = SELECT_LOW_US * CLK_MHZ;
  localparam int WD_PERCENT     = 50;
  localparam int WD_W           = 16;

  // flag vector layout
  localparam int NUM_FLAGS = 22;
  localparam int DATA_W    = 16;
  localparam int CAN_LSB   = 0;
  localparam int CAN_W     = 6;
  localparam int IO_LSB    = 6;
  localparam int IO_W      = 16;

  localparam int IDX_CANL_VDD     = 0;
  localparam int IDX_CANL_GND     = 1;
  localparam int IDX_CANH_VBAT    = 2;
  localparam int IDX_CANH_VDD     = 3;
  localparam int IDX_CANH_GND     = 4;
  localparam int IDX_CAN_WAKE     = 5;
  localparam int IDX_HS_IO3_SHORT = 6;
  localparam int IDX_HS_IO2_SHORT = 7;
  localparam int IDX_PARITY       = 8;
  localparam int IDX_SELECT_STUCK = 9;
  localparam int IDX_SUP2_UV      = 10;
  localparam int IDX_SUP1_OV      = 11;
  localparam int IDX_IO1_THERMAL  = 12;
  localparam int IDX_WD_HALF      = 13;
  localparam int IDX_WAKE_IO24    = 14;
  localparam int IDX_WAKE_IO13    = 15;
  localparam int IDX_SPI_WAKE     = 16;
  localparam int IDX_FORCED_WAKE  = 17;
  localparam int IDX_INT_TIMEOUT  = 18;
  localparam int IDX_LP_OFF       = 19;
  localparam int IDX_RESET_REQ    = 20;
  localparam int IDX_DEBUG_EXIT   = 21;

  // flags that need the cause gone before a read clears them
  localparam logic [NUM_FLAGS-1:0] RECOVER_MASK = 22'h001CDF;
  localparam logic [NUM_FLAGS-1:0] FLAG_RST     = 22'h000000;
  localparam logic                 GRP_CAN      = 1'b0;
  localparam logic                 GRP_IO       = 1'b1;

  // analog detector levels, asynchronous to mclk
  typedef struct packed {
    logic canl_vdd;
    logic canl_gnd;
    logic canh_vbat;
    logic canh_vdd;
    logic canh_gnd;
    logic high_side_switch_io3;
    logic high_side_switch_io2;
    logic supply2_undervoltage;
    logic supply1_overvoltage;
    logic io1_thermal;
    logic debug_select_pin_low;
  } sdwfb_fault_t;

  // one-cycle events from logic on mclk
  typedef struct packed {
    logic can_wake;
    logic parity_error;
    logic wake_io24;
    logic wake_io13;
    logic spi_wake;
    logic forced_wake_event;
    logic int_timeout;
    logic low_power_regulator_off_mode;
    logic reset_by_spi;
  } sdwfb_event_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } sdwfb_rd_t;

endpackage

`default_nettype wire

// *** rtl/sdwfb_flag_cell.sv ***
`timescale 1ns/100ps
`default_nettype none

module sdwfb_flag_cell
#(
  parameter bit RECOVER = 1'b0
)
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // flag control
  input  wire logic set,
  input  wire logic cause,
  input  wire logic read_clr,
  // state
  output logic      flag
);

  // with RECOVER set, a read only clears once the cause is gone
  wire clr_ok = read_clr && !(RECOVER && cause);

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      flag <= 1'b0;
    else
      flag <= set | (flag & ~clr_ok);
  end

endmodule

`default_nettype wire

// *** rtl/sdwfb_flag_bank.sv ***
// What this block does
// - Five CAN line short flags latch; clear on read after fault gone.
// - I/O3 high-side short to ground latches; clears on read after recovery.
// - I/O2 high-side short to ground latches; clears on read after recovery.
// - SPI parity error sets a flag; an I/O group flag read clears it.
// - Select held low beyond 2.0 ms sets a flag; read clears it.
// - Supply 2 undervoltage latches; clears on read after supply recovers.
// - Supply 1 overvoltage latches; clears on read after supply recovers.
// - I/O1 switch over-temperature latches; clears on read after cooling.
// - In flash mode, watchdog past half its period sets a flag.
// - Wake on I/O2 or I/O4 sets shared flag; read clears it.
// - Wake on I/O1 or I/O3 sets shared flag; read clears it.
// - SPI wake from regulator-on low power sets flag; read clears.
// - Forced timer wake sets flag; read clears it.
// - Interrupt service timeout expiry sets flag; read clears it.
// - Selecting regulator-off low power sets flag; read clears it.
// - Reset requested by SPI command sets flag; read clears it.
// - Hardware debug exit on low debug pin sets flag; read clears.
// - CAN bus wake sets flag; read clears it.
`timescale 1ns/100ps
`default_nettype none

module sdwfb_flag_bank
  import sdwfb_pkg::*;
#(
  parameter int SELECT_LOW_CYCLES = sdwfb_pkg::SELECT_LOW_CYC,
  parameter int WDW               = sdwfb_pkg::WD_W
)
(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  // detector levels and pins
  input  wire sdwfb_pkg::sdwfb_fault_t fault_in,
  input  wire logic                    spi_select_n,
  // events and mode levels from device logic
  input  wire sdwfb_pkg::sdwfb_event_t event_in,
  input  wire logic                    debug_mode,
  input  wire logic                    flash_mode,
  input  wire logic [WDW-1:0]          wd_elapsed,
  input  wire logic [WDW-1:0]          wd_period,
  // flag read
  input  wire logic                    flag_read,
  input  wire logic                    flag_read_group,
  // results
  output sdwfb_pkg::sdwfb_rd_t         rd,
  output logic [sdwfb_pkg::NUM_FLAGS-1:0] flags
);
  import sdwfb_pkg::*;

  localparam int CNT_W = $clog2(SELECT_LOW_CYCLES + 2);
  localparam logic [CNT_W-1:0] SEL_LIM = CNT_W'(SELECT_LOW_CYCLES);
  localparam logic [CNT_W-1:0] SEL_SAT = CNT_W'(SELECT_LOW_CYCLES + 1);

  generate
    if (SELECT_LOW_CYCLES < 1 || WDW < 2)
    begin : g_bad_param
      $error("sdwfb_flag_bank: unusable parameter values");
    end
  endgenerate

  function automatic logic [DATA_W-1:0] group_data
  (
    input logic [NUM_FLAGS-1:0] f,
    input logic                 grp
  );
    logic [DATA_W-1:0] d;
    d = '0;
    if (grp == GRP_CAN)
      d[CAN_W-1:0] = f[CAN_LSB +: CAN_W];
    else
      d = f[IO_LSB +: IO_W];
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for asynchronous levels

  sdwfb_fault_t fault_meta;
  sdwfb_fault_t fault_sync;
  logic         sel_meta;
  logic         sel_sync;
  logic         dbg_low_prev;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_meta   <= '0;
      fault_sync   <= '0;
      sel_meta     <= 1'b1;
      sel_sync     <= 1'b1;
      dbg_low_prev <= 1'b0;
    end
    else
    begin
      fault_meta   <= fault_in;
      fault_sync   <= fault_meta;
      sel_meta     <= spi_select_n;
      sel_sync     <= sel_meta;
      dbg_low_prev <= fault_sync.debug_select_pin_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // select low timer

  logic [CNT_W-1:0] sel_cnt;
  logic [CNT_W-1:0] next_sel_cnt;
  wire              sel_low   = !sel_sync;
  wire              sel_stuck = sel_low && (sel_cnt == SEL_LIM);

  assign next_sel_cnt = !sel_low            ? '0 :
                        (sel_cnt == SEL_SAT) ? sel_cnt :
                        sel_cnt + 1'b1;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      sel_cnt <= '0;
    else
      sel_cnt <= next_sel_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived events

  wire [WDW+7:0] wd_scaled  = (WDW+8)'(wd_elapsed) * (WDW+8)'(100);
  wire [WDW+7:0] wd_limit   = (WDW+8)'(wd_period) * (WDW+8)'(WD_PERCENT);
  wire           wd_half    = flash_mode && (wd_scaled > wd_limit);
  wire           debug_exit = debug_mode
                           && fault_sync.debug_select_pin_low
                           && !dbg_low_prev;

  ////////////////////////////////////////////////////////////////////////////
  // set and cause vectors

  logic [NUM_FLAGS-1:0] cause;
  logic [NUM_FLAGS-1:0] set;
  logic [NUM_FLAGS-1:0] read_clr;

  always_comb
  begin
    cause                   = '0;
    cause[IDX_CANL_VDD]     = fault_sync.canl_vdd;
    cause[IDX_CANL_GND]     = fault_sync.canl_gnd;
    cause[IDX_CANH_VBAT]    = fault_sync.canh_vbat;
    cause[IDX_CANH_VDD]     = fault_sync.canh_vdd;
    cause[IDX_CANH_GND]     = fault_sync.canh_gnd;
    cause[IDX_HS_IO3_SHORT] = fault_sync.high_side_switch_io3;
    cause[IDX_HS_IO2_SHORT] = fault_sync.high_side_switch_io2;
    cause[IDX_SUP2_UV]      = fault_sync.supply2_undervoltage;
    cause[IDX_SUP1_OV]      = fault_sync.supply1_overvoltage;
    cause[IDX_IO1_THERMAL]  = fault_sync.io1_thermal;
  end

  always_comb
  begin
    set                   = cause & RECOVER_MASK;
    set[IDX_CAN_WAKE]     = event_in.can_wake;
    set[IDX_PARITY]       = event_in.parity_error;
    set[IDX_SELECT_STUCK] = sel_stuck;
    set[IDX_WD_HALF]      = wd_half;
    set[IDX_WAKE_IO24]    = event_in.wake_io24;
    set[IDX_WAKE_IO13]    = event_in.wake_io13;
    set[IDX_SPI_WAKE]     = event_in.spi_wake;
    set[IDX_FORCED_WAKE]  = event_in.forced_wake_event;
    set[IDX_INT_TIMEOUT]  = event_in.int_timeout;
    set[IDX_LP_OFF]       = event_in.low_power_regulator_off_mode;
    set[IDX_RESET_REQ]    = event_in.reset_by_spi;
    set[IDX_DEBUG_EXIT]   = debug_exit;
  end

  wire read_can = flag_read && (flag_read_group == GRP_CAN);
  wire read_io  = flag_read && (flag_read_group == GRP_IO);

  ////////////////////////////////////////////////////////////////////////////
  // flag cells

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++)
    begin : g_flag
      assign read_clr[gi] = (gi < IO_LSB) ? read_can : read_io;
      sdwfb_flag_cell
      #(
        .RECOVER (RECOVER_MASK[gi])
      )
      u_cell
      (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .set      (set[gi]),
        .cause    (cause[gi]),
        .read_clr (read_clr[gi]),
        .flag     (flags[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read answer

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rd <= '0;
    else
    begin
      rd.valid <= flag_read;
      rd.data  <= flag_read ? group_data(flags, flag_read_group) : rd.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  can_short_clear_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    read_can && flags[IDX_CANL_VDD] && !fault_sync.canl_vdd
    |=> !flags[IDX_CANL_VDD]
        ##1 (!flags[IDX_CANL_VDD] || $past(fault_sync.canl_vdd))
  )
  else $error("canl short flag not cleared after recovered read");

  io3_short_set_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    $rose(fault_sync.high_side_switch_io3)
    |=> flags[IDX_HS_IO3_SHORT]
  )
  else $error("io3 short flag not latched");

  io2_short_hold_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    flags[IDX_HS_IO2_SHORT] && !read_io
    |=> flags[IDX_HS_IO2_SHORT]
  )
  else $error("io2 short flag lost without read");

  parity_flag_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    event_in.parity_error |=> flags[IDX_PARITY]
  )
  else $error("parity flag not set");

  select_stuck_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    sel_low && (sel_cnt == SEL_LIM) |=> flags[IDX_SELECT_STUCK]
  )
  else $error("select stuck flag not set at limit");

  select_early_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !flags[IDX_SELECT_STUCK] && (sel_cnt < SEL_LIM)
    |=> !flags[IDX_SELECT_STUCK]
  )
  else $error("select stuck flag set too early");

  supply2_uv_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    fault_sync.supply2_undervoltage |=> flags[IDX_SUP2_UV]
  )
  else $error("supply2 undervoltage flag not set");

  supply1_ov_hold_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    flags[IDX_SUP1_OV] && fault_sync.supply1_overvoltage
    |=> flags[IDX_SUP1_OV]
  )
  else $error("supply1 overvoltage flag cleared while present");

  thermal_hold_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    flags[IDX_IO1_THERMAL] && read_io && fault_sync.io1_thermal
    |=> flags[IDX_IO1_THERMAL]
  )
  else $error("thermal flag cleared while hot");

  wd_half_set_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    flash_mode && (wd_scaled > wd_limit) |=> flags[IDX_WD_HALF]
  )
  else $error("watchdog half flag not set");

  wake_io24_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    event_in.wake_io24 |=> flags[IDX_WAKE_IO24]
  )
  else $error("io2/io4 wake flag not set");

  wake_io13_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    event_in.wake_io13 |=> flags[IDX_WAKE_IO13]
  )
  else $error("io1/io3 wake flag not set");

  spi_wake_clr_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    read_io && flags[IDX_SPI_WAKE] && !event_in.spi_wake
    |=> !flags[IDX_SPI_WAKE]
  )
  else $error("spi wake flag not cleared by read");

  forced_wake_clr_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    read_io && !event_in.forced_wake_event |=> !flags[IDX_FORCED_WAKE]
  )
  else $error("forced wake flag not cleared by read");

  int_timeout_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    event_in.int_timeout |=> flags[IDX_INT_TIMEOUT]
  )
  else $error("interrupt timeout flag not set");

  lp_off_set_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    event_in.low_power_regulator_off_mode |=> flags[IDX_LP_OFF]
  )
  else $error("regulator off mode flag not set");

  reset_req_set_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    event_in.reset_by_spi |=> flags[IDX_RESET_REQ]
  )
  else $error("reset request flag not set");

  can_wake_clr_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    read_can && flags[IDX_CAN_WAKE] && !event_in.can_wake
    |=> !flags[IDX_CAN_WAKE]
  )
  else $error("can wake flag not cleared by read");

  ov_recover_clr_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    read_io && flags[IDX_SUP1_OV] && !fault_sync.supply1_overvoltage
    |=> !flags[IDX_SUP1_OV]
  )
  else $error("overvoltage flag kept after recovered read");

  debug_exit_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    debug_mode && $rose(fault_sync.debug_select_pin_low)
    |=> flags[IDX_DEBUG_EXIT]
  )
  else $error("debug exit flag not set");

  read_answer_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    flag_read
    |=> rd.valid
        && (rd.data == group_data($past(flags), $past(flag_read_group)))
  )
  else $error("read answer wrong or late");

endmodule

`default_nettype wire

// *** verif/sdwfb_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module sdwfb_host_model
(
  // clock
  input  wire logic                 mclk,
  // read answer
  input  wire sdwfb_pkg::sdwfb_rd_t rd,
  // select and read strobe
  output logic                      spi_select_n,
  output logic                      flag_read,
  output logic                      flag_read_group
);
  import sdwfb_pkg::*;

  initial
  begin
    spi_select_n = 1'b1;
    flag_read = 1'b0;
    flag_read_group = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // one flag read inside a short select frame
  task automatic read_group(input logic grp, output logic [15:0] data,
                            output logic ok);
    int n;
    n = 0;
    @(posedge mclk);
    #1 spi_select_n = 1'b0;
    @(posedge mclk);
    #1 flag_read = 1'b1;
    flag_read_group = grp;
    @(posedge mclk);
    #1 flag_read = 1'b0;
    while (rd.valid !== 1'b1 && n < 4)
    begin
      @(posedge mclk);
      #1 n++;
    end
    ok = (rd.valid === 1'b1);
    data = rd.data;
    flag_read_group = ~grp;
    @(posedge mclk);
    #1 spi_select_n = 1'b1;
  endtask

  // select held low with no transfer
  task automatic hold_low(input int cycles);
    @(posedge mclk);
    #1 spi_select_n = 1'b0;
    repeat (cycles) @(posedge mclk);
    #1 spi_select_n = 1'b1;
  endtask
endmodule

`default_nettype wire

// *** verif/sdwfb_flag_bank_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module sdwfb_flag_bank_tb;
  import sdwfb_pkg::*;

  localparam int SEL_CYC = 20;
  localparam int EV_IDX [9] = '{IDX_RESET_REQ, IDX_LP_OFF, IDX_INT_TIMEOUT,
    IDX_FORCED_WAKE, IDX_SPI_WAKE, IDX_WAKE_IO13, IDX_WAKE_IO24, IDX_PARITY,
    IDX_CAN_WAKE};

  logic                 mclk;
  logic                 arst_n;
  logic                 debug_mode;
  logic                 flash_mode;
  sdwfb_fault_t         fault_in;
  sdwfb_event_t         event_in;
  logic [15:0]          wd_elapsed;
  logic [15:0]          wd_period;
  wire logic            spi_select_n;
  wire logic            flag_read;
  wire logic            flag_read_group;
  wire sdwfb_rd_t       rd;
  wire logic [21:0]     flags;
  int                   err_count;
  int                   checks_done;

  sdwfb_flag_bank #(.SELECT_LOW_CYCLES(SEL_CYC), .WDW(16)) uut (
    .mclk(mclk), .arst_n(arst_n), .fault_in(fault_in),
    .spi_select_n(spi_select_n), .event_in(event_in),
    .debug_mode(debug_mode), .flash_mode(flash_mode),
    .wd_elapsed(wd_elapsed), .wd_period(wd_period), .flag_read(flag_read),
    .flag_read_group(flag_read_group), .rd(rd), .flags(flags));

  sdwfb_host_model host (
    .mclk(mclk), .rd(rd), .spi_select_n(spi_select_n),
    .flag_read(flag_read), .flag_read_group(flag_read_group));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic [15:0] grp_data(input logic [21:0] f,
                                           input logic g);
    grp_data = g ? f[21:6] : {10'h000, f[5:0]};
  endfunction

  // read one group and compare against the expected flag vector
  task automatic rd_chk(input logic g, input logic [21:0] e);
    logic [15:0] d;
    logic        ok;
    host.read_group(g, d, ok);
    check("rd_valid", 32'h1, {31'h0, ok});
    if (ok !== 1'b1)
      stop_test();
    else
      check("rd_data", {16'h0, grp_data(e, g)}, {16'h0, d});
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("flags_rst", 32'h0, {10'h0, flags});
    check("rd_rst", 32'h0, {15'h0, rd});
    step(1);
    check("flags_rst1", 32'h0, {10'h0, flags});
  endtask

  task automatic t_events();
    logic [21:0] e;
    e = '0;
    for (int i = 0; i < 9; i++)
    begin
      event_in = sdwfb_event_t'(9'h001 << i);
      step(1);
      event_in = '0;
      e[EV_IDX[i]] = 1'b1;
      check("ev_flags", {10'h0, e}, {10'h0, flags});
    end
    rd_chk(1'b0, e);
    rd_chk(1'b1, e);
    check("ev_clr", 32'h0, {10'h0, flags});
  endtask

  task automatic t_faults();
    fault_in = 11'h7FE;
    step(4);
    check("flt_set", {10'h0, RECOVER_MASK}, {10'h0, flags});
    rd_chk(1'b0, RECOVER_MASK);
    rd_chk(1'b1, RECOVER_MASK);
    check("flt_hold", {10'h0, RECOVER_MASK}, {10'h0, flags});
    fault_in = '0;
    step(4);
    check("flt_latch", {10'h0, RECOVER_MASK}, {10'h0, flags});
    rd_chk(1'b0, RECOVER_MASK);
    rd_chk(1'b1, RECOVER_MASK);
    check("flt_clr", 32'h0, {10'h0, flags});
  endtask

  task automatic t_select();
    host.hold_low(SEL_CYC);
    step(4);
    check("sel_short", 32'h0, {10'h0, flags});
    host.hold_low(SEL_CYC + 1);
    step(4);
    check("sel_long", 32'h200, {10'h0, flags});
    rd_chk(1'b1, 22'h000200);
    check("sel_clr", 32'h0, {10'h0, flags});
  endtask

  task automatic t_watchdog();
    wd_elapsed = 16'h003C;
    step(3);
    check("wd_noflash", 32'h0, {10'h0, flags});
    flash_mode = 1'b1;
    wd_elapsed = 16'h0032;
    step(3);
    check("wd_half", 32'h0, {10'h0, flags});
    wd_elapsed = 16'h0033;
    step(3);
    check("wd_past", 32'h2000, {10'h0, flags});
    flash_mode = 1'b0;
    wd_elapsed = '0;
    rd_chk(1'b1, 22'h002000);
    check("wd_clr", 32'h0, {10'h0, flags});
  endtask

  task automatic t_debug();
    fault_in.debug_select_pin_low = 1'b1;
    step(4);
    check("dbg_off", 32'h0, {10'h0, flags});
    fault_in.debug_select_pin_low = 1'b0;
    debug_mode = 1'b1;
    step(4);
    fault_in.debug_select_pin_low = 1'b1;
    step(4);
    check("dbg_exit", 32'h200000, {10'h0, flags});
    debug_mode = 1'b0;
    fault_in = '0;
    rd_chk(1'b1, 22'h200000);
    check("dbg_clr", 32'h0, {10'h0, flags});
  endtask

  task automatic t_midreset();
    fault_in = 11'h7FE;
    event_in.parity_error = 1'b1;
    step(1);
    event_in = '0;
    step(3);
    arst_n = 1'b0;
    step(2);
    check("flags_mid", 32'h0, {10'h0, flags});
    check("rd_mid", 32'h0, {15'h0, rd});
    arst_n = 1'b1;
    step(1);
    check("flags_rel1", 32'h0, {10'h0, flags});
    step(3);
    check("flt_again", {10'h0, RECOVER_MASK}, {10'h0, flags});
    fault_in = '0;
    step(3);
    rd_chk(1'b0, RECOVER_MASK);
    rd_chk(1'b1, RECOVER_MASK);
    check("mid_clr", 32'h0, {10'h0, flags});
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    fault_in = '0;
    event_in = '0;
    debug_mode = 1'b0;
    flash_mode = 1'b0;
    wd_elapsed = '0;
    wd_period = 16'h0064;
    err_count = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    #1 arst_n = 1'b1;
    t_reset();
    t_events();
    t_faults();
    t_select();
    t_watchdog();
    t_debug();
    t_midreset();
    stop_test();
  end
endmodule

`default_nettype wire
